// File: wit_consts.vh
// Constants for the watchdog/interval timer host controller.
// Assumes the timer sits on a 16-bit address bus with one shared write address.
`ifndef WIT_CONSTS_VH
`define WIT_CONSTS_VH

// Device addresses and write keys.
`define WIT_DEV_WR_ADDR 16'hFFA8
`define WIT_DEV_CSR_ADDR 16'hFFA8
`define WIT_DEV_CNT_ADDR 16'hFFA9
`define WIT_CNT_KEY 8'h5A
`define WIT_CSR_KEY 8'hA5
`define WIT_KICK_VALUE 8'h00

// Control/status field positions.
`define WIT_OVF_BIT 7
`define WIT_MODE_BIT 6
`define WIT_TME_BIT 5
`define WIT_PSS_BIT 4
`define WIT_RSTNMI_BIT 3
`define WIT_CKS_MASK 8'h07
`define WIT_CKS_DIV2 3'h0
`define WIT_STOP_MASK 8'h57
`define WIT_CTRL_RST 8'h00

// Host register offsets.
`define WIT_REG_CTRL 3'h0
`define WIT_REG_COUNT 3'h1
`define WIT_REG_CMD 3'h2
`define WIT_REG_STATUS 3'h3
`define WIT_REG_LAST_CSR 3'h4

// Command register bits.
`define WIT_CMD_KICK 0
`define WIT_CMD_RDCNT 1
`define WIT_CMD_CLR 2
`define WIT_CMD_POLL 3
`define WIT_CMD_AKICK 4
`define WIT_CMD_ACLR 5

// Timing.
`define WIT_RD_WAIT 4'h3
`define WIT_KICK_CYCLES 1000
`define WIT_OVF_READS 2'h2

`endif

// File: wit_host.v
// Host controller that drives the watchdog/interval timer through its bus.
// Assumes read data returns from the device within the read wait after a read strobe,
// and that the device's interrupt and reset indications are asynchronous levels.
`include "wit_consts.vh"

// Summary of operation
// R1: Clock select field chooses count clock.
// R2: Flag clears only when written zero.
// R3: Flag counts as seen after two reads.
// R4: Watchdog mode when mode and enable set.
// R5: Reset select gives 518-cycle chip reset.
// R6: Reset select zero gives NMI request.
// R7: Watchdog reset shares vector, status bit.
// R8: Pin reset wins, reset status set.
// R9: Never handle both NMI sources together.
// R10: Interval overflow sets flag, requests interrupt.
// R11: Interrupt stays while flag is one.
// R12: Handler clears the overflow flag.
// R13: Rewrite counter, normally zero, before overflow.
// R14: Only word writes reach the registers.
// R15: Key 5A loads low byte as count.
// R16: Key A5 loads low byte as control.
// R17: Control reads at A8, counter at A9.
// R18: Counter write beats a coincident increment.
// R19: Stop timer before changing clock select.
// R20: Stop timer before changing prescaler source.
// R21: Stop timer before switching timer mode.
// R22: Counter increments while enabled, wraps, overflows.
module wit_host #(
  parameter KICK_CYCLES = `WIT_KICK_CYCLES
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [2:0] hr_addr,
  input wire [7:0] hr_wdata,
  input wire hr_wr,
  input wire hr_rd,
  output reg [7:0] hr_rdata_r,
  output reg [15:0] dev_addr_r,
  output reg [15:0] dev_wdata_r,
  output reg dev_wr_word_r,
  output reg dev_rd_r,
  input wire [7:0] dev_rdata,
  input wire interval_overflow_irq,
  input wire dev_nmi,
  input wire dev_chip_rst
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  localparam [3:0] RD_WAIT = `WIT_RD_WAIT;
  localparam [1:0] OVF_READS = `WIT_OVF_READS;

  reg [7:0] rdata_s1_r;
  reg [7:0] rdata_s2_r;
  reg [2:0] lvl_s1_r;
  reg [2:0] lvl_s2_r;
  reg irq_d_r;

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rdata_s1_r <= 8'h00;
      rdata_s2_r <= 8'h00;
      lvl_s1_r <= 3'h0;
      lvl_s2_r <= 3'h0;
      irq_d_r <= 1'b0;
    end
    else
    begin
      rdata_s1_r <= dev_rdata;
      rdata_s2_r <= rdata_s1_r;
      lvl_s1_r <= {dev_chip_rst, dev_nmi, interval_overflow_irq};
      lvl_s2_r <= lvl_s1_r;
      irq_d_r <= lvl_s2_r[0];
    end
  end

  wire irq_s = lvl_s2_r[0];
  wire nmi_s = lvl_s2_r[1];
  wire rst_s = lvl_s2_r[2];

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_WR = 2'h1;
  localparam [1:0] S_RD = 2'h2;
  localparam [1:0] S_WAIT = 2'h3;

  reg [1:0] state_r;
  reg [3:0] wait_r;
  reg rd_is_cnt_r;
  reg [7:0] ctrl_req_r;
  reg [7:0] ctrl_shadow_r;
  reg [7:0] cnt_req_r;
  reg [7:0] last_cnt_r;
  reg [7:0] last_csr_r;
  reg [5:3] cmd_lvl_r;
  reg pend_ctrl_r;
  reg pend_cnt_r;
  reg pend_kick_r;
  reg pend_rdcnt_r;
  reg pend_clr_r;
  reg [1:0] ones_r;
  reg ovf_seen_r;
  reg [31:0] kick_tmr_r;

  wire busy = (state_r != S_IDLE) | pend_ctrl_r | pend_cnt_r | pend_kick_r |
              pend_rdcnt_r | pend_clr_r;
  wire need_stop = ctrl_shadow_r[`WIT_TME_BIT] &
                   (|((ctrl_shadow_r ^ ctrl_req_r) & `WIT_STOP_MASK)); // R19 R20 R21
  wire host_wr_ctrl = hr_wr & (hr_addr == `WIT_REG_CTRL);
  wire host_wr_cnt = hr_wr & (hr_addr == `WIT_REG_COUNT);
  wire host_wr_cmd = hr_wr & (hr_addr == `WIT_REG_CMD);
  wire host_wr_stat = hr_wr & (hr_addr == `WIT_REG_STATUS);
  wire kick_due = cmd_lvl_r[`WIT_CMD_AKICK] & (kick_tmr_r == (KICK_CYCLES - 1));
  wire irq_rise = irq_s & ~irq_d_r;
  wire rd_done = (state_r == S_WAIT) & (wait_r == 4'h0);
  wire csr_one = rdata_s2_r[`WIT_OVF_BIT];

  // ----------------------------------------------------------------
  // Host register port
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      hr_rdata_r <= 8'h00;
    end
    else if (hr_rd)
    begin
      case (hr_addr)
        `WIT_REG_CTRL: hr_rdata_r <= ctrl_shadow_r;
        `WIT_REG_COUNT: hr_rdata_r <= last_cnt_r;
        `WIT_REG_CMD: hr_rdata_r <= {2'h0, cmd_lvl_r, 3'h0};
        `WIT_REG_STATUS: hr_rdata_r <= {3'h0, rst_s, nmi_s, irq_s, ovf_seen_r, busy}; // R9
        `WIT_REG_LAST_CSR: hr_rdata_r <= last_csr_r;
        default: hr_rdata_r <= 8'h00;
      endcase
    end
    else
    begin
      hr_rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Requests and periodic service
  // ----------------------------------------------------------------
  // A pending flag is raised by the host or by an event and dropped when the
  // sequencer issues it; a new request in the issue cycle keeps it pending.
  wire issue_idle = (state_r == S_IDLE);
  wire take_ctrl = issue_idle & pend_ctrl_r & ~need_stop;
  wire take_cnt = issue_idle & ~pend_ctrl_r & pend_cnt_r;
  wire take_kick = issue_idle & ~pend_ctrl_r & ~pend_cnt_r & pend_kick_r;
  wire take_clr = issue_idle & ~pend_ctrl_r & ~pend_cnt_r & ~pend_kick_r & pend_clr_r;
  wire take_rdcnt = issue_idle & ~pend_ctrl_r & ~pend_cnt_r & ~pend_kick_r &
                    ~pend_clr_r & pend_rdcnt_r;
  wire take_poll = issue_idle & ~pend_ctrl_r & ~pend_cnt_r & ~pend_kick_r &
                   ~pend_clr_r & ~pend_rdcnt_r & cmd_lvl_r[`WIT_CMD_POLL];

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_req_r <= `WIT_CTRL_RST;
      cnt_req_r <= 8'h00;
      cmd_lvl_r <= 3'h0;
      pend_ctrl_r <= 1'b0;
      pend_cnt_r <= 1'b0;
      pend_kick_r <= 1'b0;
      pend_rdcnt_r <= 1'b0;
      pend_clr_r <= 1'b0;
      kick_tmr_r <= 32'h00000000;
    end
    else
    begin
      if (host_wr_ctrl)
      begin
        ctrl_req_r <= hr_wdata;
      end
      if (host_wr_cnt)
      begin
        cnt_req_r <= hr_wdata;
      end
      if (host_wr_cmd)
      begin
        cmd_lvl_r <= hr_wdata[5:3];
      end
      pend_ctrl_r <= host_wr_ctrl | (pend_ctrl_r & ~take_ctrl);
      pend_cnt_r <= host_wr_cnt | (pend_cnt_r & ~take_cnt);
      pend_kick_r <= (host_wr_cmd & hr_wdata[`WIT_CMD_KICK]) | kick_due |
                     (pend_kick_r & ~take_kick); // R13
      pend_rdcnt_r <= (host_wr_cmd & hr_wdata[`WIT_CMD_RDCNT]) |
                      (pend_rdcnt_r & ~take_rdcnt);
      pend_clr_r <= (host_wr_cmd & hr_wdata[`WIT_CMD_CLR]) |
                    (cmd_lvl_r[`WIT_CMD_ACLR] & irq_rise) | (pend_clr_r & ~take_clr); // R12
      if (~cmd_lvl_r[`WIT_CMD_AKICK] | kick_due)
      begin
        kick_tmr_r <= 32'h00000000;
      end
      else
      begin
        kick_tmr_r <= kick_tmr_r + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Device bus sequencer
  // ----------------------------------------------------------------
  // The overflow flag bit is written as one on every control write except the flag clear,
  // so that a reconfiguration never clears a pending overflow by accident.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= S_IDLE;
      wait_r <= 4'h0;
      rd_is_cnt_r <= 1'b0;
      ctrl_shadow_r <= `WIT_CTRL_RST;
      dev_addr_r <= 16'h0000;
      dev_wdata_r <= 16'h0000;
      dev_wr_word_r <= 1'b0;
      dev_rd_r <= 1'b0;
    end
    else
    begin
      dev_wr_word_r <= 1'b0;
      dev_rd_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (pend_ctrl_r & need_stop)
          begin
            dev_addr_r <= `WIT_DEV_WR_ADDR;
            dev_wdata_r <= {`WIT_CSR_KEY, ctrl_shadow_r[7:6], 1'b0, ctrl_shadow_r[4:0]} |
                           16'h0080; // R19 R20 R21
            ctrl_shadow_r[`WIT_TME_BIT] <= 1'b0;
            dev_wr_word_r <= 1'b1;
            state_r <= S_WR;
          end
          else if (take_ctrl)
          begin
            dev_addr_r <= `WIT_DEV_WR_ADDR;
            dev_wdata_r <= {`WIT_CSR_KEY, ctrl_req_r | 8'h80}; // R14 R16 R2 R1 R4
            ctrl_shadow_r <= ctrl_req_r;
            dev_wr_word_r <= 1'b1;
            state_r <= S_WR;
          end
          else if (take_cnt | take_kick)
          begin
            dev_addr_r <= `WIT_DEV_WR_ADDR;
            dev_wdata_r <= {`WIT_CNT_KEY, take_cnt ? cnt_req_r : `WIT_KICK_VALUE}; // R15 R13
            dev_wr_word_r <= 1'b1;
            state_r <= S_WR;
          end
          else if (take_clr)
          begin
            dev_addr_r <= `WIT_DEV_WR_ADDR;
            dev_wdata_r <= {`WIT_CSR_KEY, 1'b0, ctrl_shadow_r[6:0]}; // R2 R12
            dev_wr_word_r <= 1'b1;
            state_r <= S_WR;
          end
          else if (take_rdcnt | take_poll)
          begin
            dev_addr_r <= take_rdcnt ? `WIT_DEV_CNT_ADDR : `WIT_DEV_CSR_ADDR; // R17
            rd_is_cnt_r <= take_rdcnt;
            dev_rd_r <= 1'b1;
            state_r <= S_RD;
          end
        end
        S_WR:
        begin
          state_r <= S_IDLE;
        end
        S_RD:
        begin
          wait_r <= RD_WAIT;
          state_r <= S_WAIT;
        end
        S_WAIT:
        begin
          if (wait_r == 4'h0)
          begin
            state_r <= S_IDLE;
          end
          else
          begin
            wait_r <= wait_r - 4'h1;
          end
        end
        default:
        begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture and overflow detection
  // ----------------------------------------------------------------
  // A single read of one is not trusted while polling; the flag must read as
  // one on consecutive polls before it is reported.
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      last_cnt_r <= 8'h00;
      last_csr_r <= 8'h00;
      ones_r <= 2'h0;
      ovf_seen_r <= 1'b0;
    end
    else
    begin
      if (rd_done & rd_is_cnt_r)
      begin
        last_cnt_r <= rdata_s2_r;
      end
      if (rd_done & ~rd_is_cnt_r)
      begin
        last_csr_r <= rdata_s2_r;
        if (~csr_one)
        begin
          ones_r <= 2'h0;
        end
        else if (ones_r != OVF_READS)
        begin
          ones_r <= ones_r + 2'h1;
        end
      end
      if (rd_done & ~rd_is_cnt_r & csr_one & (ones_r == (OVF_READS - 2'h1)))
      begin
        ovf_seen_r <= 1'b1; // R3
      end
      else if (host_wr_stat & hr_wdata[1])
      begin
        ovf_seen_r <= 1'b0;
      end
    end
  end

endmodule // wit_host

// File: wit_host_properties.sv
// Port assertions for the timer host controller.
// Assumes it is bound onto every wit_host instance.
module wit_host_properties (
  input wire ref_clk,
  input wire sys_rst,
  input wire [2:0] hr_addr,
  input wire [7:0] hr_wdata,
  input wire hr_wr,
  input wire hr_rd,
  input wire [7:0] hr_rdata_r,
  input wire [15:0] dev_addr_r,
  input wire [15:0] dev_wdata_r,
  input wire dev_wr_word_r,
  input wire dev_rd_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // The last control byte sent, so a running timer is seen.
  // ----
  logic [7:0] csr_r;
  wire ctl_wr = dev_wr_word_r && dev_wdata_r[15:8] == 8'hA5;
  always @(posedge ref_clk)
    if (sys_rst)
      csr_r <= 8'h00;
    else if (ctl_wr)
      csr_r <= dev_wdata_r[7:0];
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_write_addr: assert property (dev_wr_word_r |-> dev_addr_r == 16'hFFA8)
    else $error("word write off the shared address");
  a_write_key: assert property (dev_wr_word_r |-> dev_wdata_r[15:8] inside {8'h5A, 8'hA5})
    else $error("word write without a key");
  a_read_addr: assert property (dev_rd_r |-> dev_addr_r inside {16'hFFA8, 16'hFFA9})
    else $error("read off the register addresses");
  a_write_gap: assert property (dev_wr_word_r |=> !dev_wr_word_r && !dev_rd_r)
    else $error("device strobes too close");
  a_stop_first: assert property (ctl_wr && csr_r[5] && dev_wdata_r[5] |-> ((dev_wdata_r[7:0] ^ csr_r) & 8'h57) == 8'h00)
    else $error("fields changed on a running timer");
  a_ctrl_sent: assert property (hr_wr && hr_addr == 3'h0 |-> ##[1:40] ctl_wr)
    else $error("control write not sent");
  a_kick_sent: assert property (hr_wr && hr_addr == 3'h2 && hr_wdata[0] |-> ##[1:60] dev_wr_word_r && dev_wdata_r == 16'h5A00)
    else $error("kick not sent");
  a_clear_sent: assert property (hr_wr && hr_addr == 3'h2 && hr_wdata[2] |-> ##[1:60] ctl_wr && !dev_wdata_r[7])
    else $error("flag clear not sent");
  a_rdata_idle: assert property (!$past(hr_rd) |-> hr_rdata_r == 8'h00)
    else $error("read data outside its cycle");
endmodule // wit_host_properties

bind wit_host wit_host_properties u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .hr_addr(hr_addr), .hr_wdata(hr_wdata), .hr_wr(hr_wr), .hr_rd(hr_rd),
  .hr_rdata_r(hr_rdata_r), .dev_addr_r(dev_addr_r), .dev_wdata_r(dev_wdata_r),
  .dev_wr_word_r(dev_wr_word_r), .dev_rd_r(dev_rd_r));

// File: wit_timer_model.sv
// Behavioural model of the watchdog/interval timer device.
// Assumes one clock; every undocumented clock code counts at half rate too.
module wit_timer_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire [15:0] dev_addr,
  input wire [15:0] dev_wdata,
  input wire dev_wr_word,
  input wire dev_rd,
  output logic [7:0] dev_rdata,
  output wire irq,
  output logic nmi,
  output wire chip_rst
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] csr_r;
  logic [7:0] cnt_r;
  logic tick_r;
  logic [9:0] rst_cnt_r;
  logic [2:0] hold_r;
  wire wr_ok = dev_wr_word && dev_addr == 16'hFFA8;
  wire key_cnt = wr_ok && dev_wdata[15:8] == 8'h5A;
  wire key_csr = wr_ok && dev_wdata[15:8] == 8'hA5;
  wire tick = csr_r[5] && tick_r;
  wire wrap = tick && cnt_r == 8'hFF;
  assign irq = csr_r[7] && !csr_r[6];
  assign chip_rst = rst_cnt_r != 10'd0;
  always @(posedge ref_clk)
    if (sys_rst)
    begin
      {csr_r, cnt_r, tick_r, rst_cnt_r, nmi} <= '0;
    end
    else if (chip_rst)
      rst_cnt_r <= rst_cnt_r - 10'd1;
    else if (wrap && csr_r[6] && csr_r[3])
    begin
      rst_cnt_r <= 10'd518;
      {csr_r, cnt_r} <= 16'h0000;
    end
    else
    begin
      tick_r <= csr_r[5] ? !tick_r : 1'b0;
      if (key_csr)
        csr_r <= {csr_r[7] & dev_wdata[7], dev_wdata[6:0]};
      if (wrap && !csr_r[6])
        csr_r[7] <= 1'b1;
      nmi <= key_csr ? 1'b0 : nmi | (wrap && csr_r[6]);
      if (key_cnt)
        cnt_r <= dev_wdata[7:0];
      else if (tick)
        cnt_r <= cnt_r + 8'h01;
    end
  // A released read bus toggles, so stale data can never pass.
  always @(posedge ref_clk)
    if (dev_rd)
    begin
      dev_rdata <= dev_addr == 16'hFFA8 ? csr_r : cnt_r;
      hold_r <= 3'd6;
    end
    else if (hold_r != 3'd0)
      hold_r <= hold_r - 3'd1;
    else
      dev_rdata <= ~dev_rdata;
endmodule // wit_timer_model

// File: test_wit_host.sv
// Self-checking bench for the timer host controller.
// Assumes the device model stands on the far side of the device bus.
module test_wit_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] hr_addr = 3'h0;
  logic [7:0] hr_wdata = 8'h00;
  logic hr_wr = 1'b0;
  logic hr_rd = 1'b0;
  wire [7:0] hr_rdata_r, dev_rdata;
  wire [15:0] dev_addr_r, dev_wdata_r;
  wire dev_wr_word_r, dev_rd_r, irq, nmi, crst;
  int fail_count = 0;
  int comparisons = 0;
  int exp_q[$];
  logic [7:0] v;
  wit_host #(.KICK_CYCLES(20)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .hr_addr(hr_addr),
    .hr_wdata(hr_wdata), .hr_wr(hr_wr), .hr_rd(hr_rd), .hr_rdata_r(hr_rdata_r),
    .dev_addr_r(dev_addr_r), .dev_wdata_r(dev_wdata_r), .dev_wr_word_r(dev_wr_word_r),
    .dev_rd_r(dev_rd_r), .dev_rdata(dev_rdata), .interval_overflow_irq(irq),
    .dev_nmi(nmi), .dev_chip_rst(crst));
  wit_timer_model M (.ref_clk(ref_clk), .sys_rst(sys_rst), .dev_addr(dev_addr_r),
    .dev_wdata(dev_wdata_r), .dev_wr_word(dev_wr_word_r), .dev_rd(dev_rd_r),
    .dev_rdata(dev_rdata), .irq(irq), .nmi(nmi), .chip_rst(crst));
  initial
    forever #2.5 ref_clk = !ref_clk;
  // ----
  // Host port tasks
  // ----
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    hr_addr <= a;
    hr_wdata <= d;
    hr_wr <= 1'b1;
    @(posedge ref_clk);
    hr_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    hr_addr <= a;
    hr_rd <= 1'b1;
    @(posedge ref_clk);
    hr_rd <= 1'b0;
    #1 d = hr_rdata_r;
    @(posedge ref_clk);
  endtask
  // Polls one status bit; running out of tries ends the run.
  task automatic wait_st(input int b, input logic e, input int lim);
    logic [7:0] s;
    int n;
    n = 0;
    do
    begin
      rd(3'h3, s);
      n++;
    end
    while (s[b] !== e && n < lim);
    chk("status bit", e, s[b]);
    if (s[b] !== e)
      end_of_test();
  endtask
  initial
  begin
    void'($urandom(32'h6EBE9E4D));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 6; a++)
    begin
      rd(a[2:0], v);
      chk("reset read", 8'h00, v);
    end
    $display("test reset done");
    repeat (4)
    begin
      v = 8'($urandom);
      exp_q.push_back(v);
      wr(3'h1, v);
      wait_st(0, 1'b0, 20);
      chk("device count", exp_q[$], M.cnt_r);
      wr(3'h2, 8'h02);
      wait_st(0, 1'b0, 20);
      rd(3'h1, v);
      chk("count read", exp_q.pop_front(), v);
    end
    $display("test count done");
    wr(3'h0, 8'h20);
    wait_st(2, 1'b1, 400);
    chk("flag set", 1'b1, M.csr_r[7]);
    wr(3'h2, 8'h04);
    wait_st(2, 1'b0, 40);
    chk("flag cleared", 1'b0, M.csr_r[7]);
    $display("test interval done");
    wr(3'h2, 8'h08);
    wait_st(1, 1'b1, 400);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h02);
    rd(3'h3, v);
    chk("seen cleared", 1'b0, v[1]);
    rd(3'h4, v);
    chk("last csr", 8'hA0, v);
    wr(3'h2, 8'h04);
    $display("test poll done");
    wr(3'h0, 8'h60);
    wait_st(3, 1'b1, 400);
    chk("still counting", 1'b1, M.csr_r[5]);
    wr(3'h2, 8'h01);
    wait_st(0, 1'b0, 30);
    chk("kicked low", 1'b1, M.cnt_r < 8'h10);
    rd(3'h0, v);
    chk("ctrl shadow", 8'h60, v);
    $display("test nmi done");
    wr(3'h0, 8'h68);
    wait_st(4, 1'b1, 400);
    wait_st(4, 1'b0, 400);
    $display("test reset path done");
    wr(3'h2, 8'h20);
    wr(3'h0, 8'h20);
    wait_st(2, 1'b1, 400);
    wait_st(2, 1'b0, 10);
    chk("auto clear", 1'b0, M.csr_r[7]);
    wr(3'h2, 8'h10);
    wr(3'h0, 8'h68);
    repeat (1200) @(posedge ref_clk);
    rd(3'h3, v);
    chk("no reset", 1'b0, v[4]);
    chk("auto kick", 1'b1, M.cnt_r < 8'h10);
    $display("test auto service done");
    end_of_test();
  end
endmodule // test_wit_host
